/* File: dv/test_pwm_counter_irq_status.sv */
`timescale 1ns/10ps
module test_pwm_counter_irq_status;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pwm_stat_pkg::grp_events_t ev_a = '0;
  pwm_stat_pkg::grp_events_t ev_b = '0;
  logic irq_a_o;
  logic irq_b_o;
  int n_fail = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic er;

  pwm_counter_irq_status pwm_counter_irq_status_inst (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .grp_a_ev_i(ev_a), .grp_b_ev_i(ev_b),
    .irq_a_o(irq_a_o), .irq_b_o(irq_b_o));

  always #2.5 mclk_i = ~mclk_i;

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  // Waits for pready with no assumed latency; one idle edge after release
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, x);
  endtask : rdc

  // Latch pulses go to group A only
  task automatic pulse(input logic g, input logic [3:0] z, r, f);
    ev_a.zero_reach <= g ? 4'h0 : z;
    ev_b.zero_reach <= g ? z : 4'h0;
    ev_a.rise_latch <= r;
    ev_a.fall_latch <= f;
    @(posedge mclk_i);
    ev_a.zero_reach <= 4'h0;
    ev_b.zero_reach <= 4'h0;
    ev_a.rise_latch <= 4'h0;
    ev_a.fall_latch <= 4'h0;
    @(posedge mclk_i);
  endtask : pulse

  task automatic reset_values;
    logic [7:0] offs [7] = '{8'h14, 8'h20, 8'h2c, 8'h38, 8'h3c, 8'h40, 8'h44};
    for (int g = 0; g < 2; g++)
      for (int i = 0; i < 7; i++)
        rdc({3'h0, g[0], offs[i]}, 32'h0000_0000);
  endtask : reset_values

  task automatic readback;
    for (int i = 0; i < 4; i++)
    begin
      ev_a.count[i] <= 16'hf000 | 16'(i);
      ev_b.count[i] <= 16'h0a50 | 16'(i);
    end
    @(posedge mclk_i);
    for (int i = 0; i < 4; i++)
    begin
      rdc(12'h014 + 12'(12 * i), 32'h0000_f000 | i);
      rdc(12'h114 + 12'(12 * i), 32'h0000_0a50 | i);
    end
    apb(1'b1, 12'h014, 32'hffff_ffff);
    rdc(12'h014, 32'h0000_f000);
    rdc(12'h03c, 32'h0000_0000);
  endtask : readback

  task automatic irq_flow;
    apb(1'b1, 12'h040, 32'h0000_0005);
    rdc(12'h040, 32'h0000_0005);
    pulse(1'b0, 4'hf, 4'h0, 4'h0);
    rdc(12'h044, 32'h0000_0005);
    chk({31'h0, irq_a_o}, 32'h1);
    chk({31'h0, irq_b_o}, 32'h0);
    apb(1'b1, 12'h044, 32'h0000_0001);
    rdc(12'h044, 32'h0000_0004);
    chk({31'h0, irq_a_o}, 32'h1);
    apb(1'b1, 12'h044, 32'h0000_0004);
    rdc(12'h044, 32'h0000_0000);
    chk({31'h0, irq_a_o}, 32'h0);
    apb(1'b1, 12'h140, 32'h0000_0008);
    pulse(1'b1, 4'hf, 4'h0, 4'h0);
    rdc(12'h144, 32'h0000_0008);
    chk({31'h0, irq_b_o}, 32'h1);
    apb(1'b1, 12'h144, 32'h0000_0008);
    chk({31'h0, irq_b_o}, 32'h0);
  endtask : irq_flow

  task automatic latch_clear;
    pulse(1'b0, 4'h0, 4'h3, 4'h8);
    rdc(12'h048, 32'h0000_0083);
    apb(1'b1, 12'h048, 32'hffff_fffe);
    rdc(12'h048, 32'h0000_0082);
    apb(1'b1, 12'h03c, 32'h0000_0001);
    rdc(12'h03c, 32'h0000_0001);
    apb(1'b1, 12'h048, 32'h0000_0002);
    rdc(12'h048, 32'h0000_0080);
  endtask : latch_clear

  // Misaligned write must not reach the enable register
  task automatic refused;
    apb(1'b0, 12'h0f0, 32'h0000_0000);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h042, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    rdc(12'h040, 32'h0000_0005);
  endtask : refused

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  initial
  begin
    #100000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    reset_values();
    readback();
    irq_flow();
    latch_clear();
    refused();
    complete_run();
  end
endmodule : test_pwm_counter_irq_status

/* File: logic/pwm_counter_irq_status.sv */
`timescale 1ns/10ps
module pwm_counter_irq_status
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input pwm_stat_pkg::grp_events_t grp_a_ev_i,
  input pwm_stat_pkg::grp_events_t grp_b_ev_i,
  output logic irq_a_o,
  output logic irq_b_o
);
  pwm_stat_pkg::apb_state_t state;
  pwm_stat_pkg::apb_state_t next_state;
  logic err;
  logic next_err;
  logic [1:0] wr;
  logic [1:0] rd;
  logic [1:0] hit;
  logic [31:0] rdata [2];
  logic grp;
  logic known;

  // Group B lives one page above group A
  assign grp = paddr[pwm_stat_pkg::GRP_SEL_BIT];
  assign known = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);

  // Reads sample in setup so data comes from a flop; writes land at completion
  always_comb
  begin
    wr = '0;
    rd = '0;
    if (psel && !penable && known)
      rd[grp] = !pwrite;
    if (psel && penable && pready && known)
      wr[grp] = pwrite;
  end

  always_comb
  begin
    next_state = state;
    next_err = err;
    case (state)
      pwm_stat_pkg::ST_IDLE:
        if (psel && !penable)
        begin
          next_state = pwm_stat_pkg::ST_ACCESS;
          next_err = !known || !hit[grp];
        end
      pwm_stat_pkg::ST_ACCESS:
        next_state = pwm_stat_pkg::ST_IDLE;
      default:
        next_state = pwm_stat_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state <= pwm_stat_pkg::ST_IDLE;
      err <= 1'b0;
    end
    else
    begin
      state <= next_state;
      err <= next_err;
    end
  end

  assign pready = (state == pwm_stat_pkg::ST_ACCESS);
  assign pslverr = pready && err;
  assign prdata = (pready && !err) ? rdata[grp] : 32'h0000_0000;

  pwm_stat_group u_grp_a (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ev_i(grp_a_ev_i),
    .wr_i(wr[0]),
    .rd_i(rd[0]),
    .addr_i(paddr[7:0]),
    .wdata_i(pwdata),
    .rdata_o(rdata[0]),
    .hit_o(hit[0]),
    .irq_o(irq_a_o)
  );

  pwm_stat_group u_grp_b (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ev_i(grp_b_ev_i),
    .wr_i(wr[1]),
    .rd_i(rd[1]),
    .addr_i(paddr[7:0]),
    .wdata_i(pwdata),
    .rdata_o(rdata[1]),
    .hit_o(hit[1]),
    .irq_o(irq_b_o)
  );

  chk_one_wait: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (psel && !penable) |=> pready)
    else $error("pready not one cycle after setup");
endmodule : pwm_counter_irq_status

/* File: logic/pwm_stat_group.sv */
`timescale 1ns/10ps
module pwm_stat_group
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input pwm_stat_pkg::grp_events_t ev_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic hit_o,
  output logic irq_o
);
  logic clear_pol;
  logic [pwm_stat_pkg::NUM_CH-1:0] irq_en;
  logic [pwm_stat_pkg::NUM_CH-1:0] flags;
  logic [pwm_stat_pkg::NUM_CH-1:0] rise_ind;
  logic [pwm_stat_pkg::NUM_CH-1:0] fall_ind;
  logic [31:0] rdata;
  logic next_clear_pol;
  logic [pwm_stat_pkg::NUM_CH-1:0] next_irq_en;
  logic [pwm_stat_pkg::NUM_CH-1:0] next_flags;
  logic [pwm_stat_pkg::NUM_CH-1:0] next_rise_ind;
  logic [pwm_stat_pkg::NUM_CH-1:0] next_fall_ind;
  logic [31:0] next_rdata;
  logic [pwm_stat_pkg::NUM_CH-1:0] ind_clr_r;
  logic [pwm_stat_pkg::NUM_CH-1:0] ind_clr_f;

  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction : zext16

  always_comb
  begin
    next_clear_pol = clear_pol;
    next_irq_en = irq_en;
    next_flags = flags;
    next_rise_ind = rise_ind;
    next_fall_ind = fall_ind;
    next_rdata = rdata;
    ind_clr_r = '0;
    ind_clr_f = '0;
    // Decode by address alone so a write is judged before it lands
    case (addr_i)
      pwm_stat_pkg::OFF_READBACK_CH0, pwm_stat_pkg::OFF_READBACK_CH1,
      pwm_stat_pkg::OFF_READBACK_CH2, pwm_stat_pkg::OFF_READBACK_CH3,
      pwm_stat_pkg::OFF_CLEAR_POL, pwm_stat_pkg::OFF_IRQ_ENABLE,
      pwm_stat_pkg::OFF_IRQ_FLAGS, pwm_stat_pkg::OFF_LATCH_IND,
      pwm_stat_pkg::OFF_IRQ_CLEAR:
        hit_o = 1'b1;
      default:
        hit_o = 1'b0;
    endcase
    if (wr_i)
    begin
      case (addr_i)
        pwm_stat_pkg::OFF_CLEAR_POL:
          next_clear_pol = wdata_i[pwm_stat_pkg::CLEAR_POL_BIT];
        pwm_stat_pkg::OFF_IRQ_ENABLE:
          next_irq_en = wdata_i[3:0];
        pwm_stat_pkg::OFF_IRQ_FLAGS, pwm_stat_pkg::OFF_IRQ_CLEAR:
          next_flags = flags & ~wdata_i[3:0];
        pwm_stat_pkg::OFF_LATCH_IND:
        begin
          // Polarity picks which written value clears
          ind_clr_r = clear_pol ? wdata_i[3:0] : ~wdata_i[3:0];
          ind_clr_f = clear_pol ? wdata_i[7:4] : ~wdata_i[7:4];
        end
        pwm_stat_pkg::OFF_READBACK_CH0, pwm_stat_pkg::OFF_READBACK_CH1,
        pwm_stat_pkg::OFF_READBACK_CH2, pwm_stat_pkg::OFF_READBACK_CH3:
          next_clear_pol = clear_pol;
        default:
          next_clear_pol = clear_pol;
      endcase
      next_rise_ind = rise_ind & ~ind_clr_r;
      next_fall_ind = fall_ind & ~ind_clr_f;
    end
    if (rd_i)
    begin
      case (addr_i)
        pwm_stat_pkg::OFF_READBACK_CH0: next_rdata = zext16(ev_i.count[0]);
        pwm_stat_pkg::OFF_READBACK_CH1: next_rdata = zext16(ev_i.count[1]);
        pwm_stat_pkg::OFF_READBACK_CH2: next_rdata = zext16(ev_i.count[2]);
        pwm_stat_pkg::OFF_READBACK_CH3: next_rdata = zext16(ev_i.count[3]);
        pwm_stat_pkg::OFF_CLEAR_POL: next_rdata = {31'h0, clear_pol};
        pwm_stat_pkg::OFF_IRQ_ENABLE: next_rdata = {28'h0, irq_en};
        pwm_stat_pkg::OFF_IRQ_FLAGS: next_rdata = {28'h0, flags};
        pwm_stat_pkg::OFF_LATCH_IND: next_rdata = {24'h0, fall_ind, rise_ind};
        pwm_stat_pkg::OFF_IRQ_CLEAR: next_rdata = pwm_stat_pkg::RESET_VAL;
        default:
          next_rdata = pwm_stat_pkg::RESET_VAL;
      endcase
    end
    // Set after clear so a same-cycle event is never lost
    next_flags = next_flags | (ev_i.zero_reach & irq_en);
    next_rise_ind = next_rise_ind | ev_i.rise_latch;
    next_fall_ind = next_fall_ind | ev_i.fall_latch;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      clear_pol <= 1'b0;
      irq_en <= '0;
      flags <= '0;
      rise_ind <= '0;
      fall_ind <= '0;
      rdata <= pwm_stat_pkg::RESET_VAL;
    end
    else
    begin
      clear_pol <= next_clear_pol;
      irq_en <= next_irq_en;
      flags <= next_flags;
      rise_ind <= next_rise_ind;
      fall_ind <= next_fall_ind;
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;
  assign irq_o = |flags;

  chk_flag_sets: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ev_i.zero_reach[0] && irq_en[0]) |=> flags[0])
    else $error("flag 0 did not set on zero reach");
  chk_flag_masked: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!flags[1] && !(ev_i.zero_reach[1] && irq_en[1])) |=> !flags[1])
    else $error("flag 1 set without enabled event");
  chk_flag_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == pwm_stat_pkg::OFF_IRQ_FLAGS && wdata_i[2]
     && !ev_i.zero_reach[2]) |=> !flags[2])
    else $error("flag 2 not cleared by write one");
  chk_irq_level: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(flags[3]) |-> irq_o)
    else $error("irq low with flag set");
  chk_count_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rd_i && addr_i == pwm_stat_pkg::OFF_READBACK_CH2)
    |=> rdata_o == {16'h0000, $past(ev_i.count[2])})
    else $error("readback 2 wrong");
  chk_pol_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == pwm_stat_pkg::OFF_LATCH_IND && !clear_pol
     && !wdata_i[0] && !ev_i.rise_latch[0]) |=> !rise_ind[0])
    else $error("write zero failed to clear indicator");
  chk_ind_set: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ev_i.fall_latch[3] |=> fall_ind[3])
    else $error("fall indicator not set");
  chk_ro_count: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == pwm_stat_pkg::OFF_READBACK_CH0)
    |=> clear_pol == $past(clear_pol))
    else $error("readback write disturbed state");
endmodule : pwm_stat_group

/* File: logic/pwm_stat_pkg.sv */
// Operation
// - Each channel's readback register shows the 16-bit down counter, sampled in the setup cycle of the read, in bits 15..0.
// - Readback registers are read-only, read the count input even just after reset, four per group.
// - Bit 0 of the clear-polarity register picks write-0 or write-1 clearing of latch indicators.
// - The irq enable register holds one enable per channel in bits 3..0.
// - A channel's flag sets when its counter reaches zero while its enable is 1.
// - Groups A and B carry identical registers at the same relative offsets.
// - A latch indicator sets when a capture edge latches the counter.
package pwm_stat_pkg;
  localparam int NUM_CH = 4;
  localparam int CNT_W = 16;
  localparam int NUM_GRP = 2;
  localparam logic [7:0] OFF_READBACK_CH0 = 8'h14;
  localparam logic [7:0] OFF_READBACK_CH1 = 8'h20;
  localparam logic [7:0] OFF_READBACK_CH2 = 8'h2c;
  localparam logic [7:0] OFF_READBACK_CH3 = 8'h38;
  localparam logic [7:0] OFF_CLEAR_POL = 8'h3c;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h40;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h44;
  localparam logic [7:0] OFF_LATCH_IND = 8'h48;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h4c;
  localparam logic [8:0] GRP_B_BASE = 9'h100;
  localparam int GRP_SEL_BIT = 8;
  localparam int CLEAR_POL_BIT = 0;
  localparam int RISE_IND_LSB = 0;
  localparam int FALL_IND_LSB = 4;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;

  typedef struct packed {
    logic [NUM_CH-1:0][CNT_W-1:0] count;
    logic [NUM_CH-1:0] zero_reach;
    logic [NUM_CH-1:0] rise_latch;
    logic [NUM_CH-1:0] fall_latch;
  } grp_events_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01
  } apb_state_t;
endpackage : pwm_stat_pkg
